// File: rtl/fhc_consts.vh
// Timing and layout constants for the parallel flash host controller
`ifndef FHC_CONSTS_VH
`define FHC_CONSTS_VH

// ****************************************
// Clock
// ****************************************
`define FHC_CLK_PERIOD_NS   100

// ****************************************
// Device timing in ns
// ****************************************
`define FHC_ADDRESS_ACCESS_TIME_NS  70
`define FHC_WE_LOW_NS               35
`define FHC_WE_HIGH_NS              30
`define FHC_RESET_PULSE_MIN_NS      500
`define FHC_RESET_RECOVERY_TIME_NS  50
`define FHC_READY_BUSY_NS           20000
`define FHC_READY_IDLE_NS           500

// ****************************************
// Derived cycle counts
// ****************************************
// Least times round up
`define FHC_CYC_UP(t) (((t) + `FHC_CLK_PERIOD_NS - 1) / `FHC_CLK_PERIOD_NS)
// Longest times round down, never below one cycle
`define FHC_CYC_DN(t) (((t) < `FHC_CLK_PERIOD_NS) ? 1 : \
                       ((t) / `FHC_CLK_PERIOD_NS))
`define FHC_CYC_ACC       `FHC_CYC_UP(`FHC_ADDRESS_ACCESS_TIME_NS)
`define FHC_CYC_WE_LOW    `FHC_CYC_UP(`FHC_WE_LOW_NS)
`define FHC_CYC_WE_HIGH   `FHC_CYC_UP(`FHC_WE_HIGH_NS)
`define FHC_CYC_RST_PULSE `FHC_CYC_UP(`FHC_RESET_PULSE_MIN_NS)
`define FHC_CYC_RST_RECOV `FHC_CYC_UP(`FHC_RESET_RECOVERY_TIME_NS)
`define FHC_CYC_RDY_BUSY  `FHC_CYC_UP(`FHC_READY_BUSY_NS)
`define FHC_CYC_RDY_IDLE  `FHC_CYC_UP(`FHC_READY_IDLE_NS)
`define FHC_SYNC_STAGES   2

// ****************************************
// Bus layout
// ****************************************
`define FHC_ADDR_W        20
`define FHC_DATA_W        16
`define FHC_OE_WORD       16'hffff
`define FHC_OE_BYTE_WR    16'h80ff
`define FHC_OE_BYTE_RD    16'h8000

`endif

// File: rtl/fhc_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fhc_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] d_i,
  input  wire [W-1:0] rst_val_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_ff <= rst_val_i;
      sync_ff <= rst_val_i;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule

// File: rtl/fhc_top.v
// Host-side controller driving an asynchronous parallel flash
`timescale 1ns/1ps
`include "fhc_consts.vh"
module fhc_top (
  input  wire        CLK_I,
  input  wire        NRST_I,
  input  wire        REQ_I,
  input  wire        WR_I,
  input  wire        BYTE_MODE_I,
  input  wire [20:0] ADDR_I,
  input  wire [15:0] WDATA_I,
  input  wire        RST_REQ_I,
  input  wire [15:0] DQ_I,
  input  wire        READY_BUSY_N_I,
  output reg         READY_O,
  output reg         DONE_O,
  output reg  [15:0] RDATA_O,
  output reg         BUSY_O,
  output reg         ABORTED_O,
  output reg         CE_N_O,
  output reg         OE_N_O,
  output reg         WE_N_O,
  output reg         BYTE_N_O,
  output reg         RESET_N_O,
  output reg  [19:0] ADDR_O,
  output reg  [15:0] DQ_O,
  output reg  [15:0] DQ_OE_O
);
  // ****************************************
  // States and counts
  // ****************************************
  localparam [7:0] ST_RST_LOW  = 8'h01;
  localparam [7:0] ST_RST_WAIT = 8'h02;
  localparam [7:0] ST_RECOV    = 8'h04;
  localparam [7:0] ST_IDLE     = 8'h08;
  localparam [7:0] ST_RD       = 8'h10;
  localparam [7:0] ST_WR       = 8'h20;
  localparam [7:0] ST_WR_HOLD  = 8'h40;

  // Counts follow the timing macros, so another speed grade is one edit
  localparam integer CYC_RD_N    = `FHC_CYC_ACC + `FHC_SYNC_STAGES;
  localparam integer CYC_WE_LO_N = `FHC_CYC_WE_LOW;
  localparam integer CYC_WE_HI_N = `FHC_CYC_WE_HIGH;
  localparam integer CYC_RP_N    = `FHC_CYC_RST_PULSE;
  localparam integer CYC_RH_N    = `FHC_CYC_RST_RECOV;
  localparam integer CYC_RDY_B_N = `FHC_CYC_RDY_BUSY;
  localparam integer CYC_RDY_I_N = `FHC_CYC_RDY_IDLE;

  localparam [15:0] CYC_RD     = CYC_RD_N[15:0];
  localparam [15:0] CYC_WE_LO  = CYC_WE_LO_N[15:0];
  localparam [15:0] CYC_WE_HI  = CYC_WE_HI_N[15:0];
  localparam [15:0] CYC_RP     = CYC_RP_N[15:0];
  localparam [15:0] CYC_RH     = CYC_RH_N[15:0];
  localparam [15:0] CYC_RDY_B  = CYC_RDY_B_N[15:0];
  localparam [15:0] CYC_RDY_I  = CYC_RDY_I_N[15:0];

  reg  [7:0]  state_ff;
  reg  [15:0] cnt_ff;
  wire [16:0] sync_q;
  wire [15:0] dq_s;
  wire        rb_s;
  wire        cnt_done;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Ready pin resets as ready, so no false busy follows reset
  fhc_sync #(
    .W (17)
  ) u_sync (
    .clk_i     (CLK_I),
    .nrst_i    (NRST_I),
    .d_i       ({READY_BUSY_N_I, DQ_I}),
    .rst_val_i (17'h10000),
    .q_o       (sync_q)
  );
  assign dq_s     = sync_q[15:0];
  assign rb_s     = sync_q[16];
  assign cnt_done = (cnt_ff == 16'h0000);

  // ****************************************
  // Bus placement
  // ****************************************
  // Byte addresses shift down one; bit 0 leaves on data pin 15
  function [19:0] pin_addr;
    input        byte_mode;
    input [20:0] addr;
    begin
      if (byte_mode) begin
        pin_addr = addr[20:1];
      end else begin
        pin_addr = addr[19:0];
      end
    end
  endfunction

  // Byte reads keep the low lane only; pins 14 to 8 float, pin 15 carries the address LSB
  function [15:0] rd_lane;
    input        word_cfg;
    input [15:0] dq;
    begin
      if (word_cfg) begin
        rd_lane = dq;
      end else begin
        rd_lane = {8'h00, dq[7:0]};
      end
    end
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  // Power-up starts with a device reset pulse so array-read is known
  always @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_ff  <= ST_RST_LOW;
      cnt_ff    <= CYC_RP;
      READY_O   <= 1'b0;
      DONE_O    <= 1'b0;
      RDATA_O   <= 16'h0000;
      BUSY_O    <= 1'b0;
      ABORTED_O <= 1'b0;
      CE_N_O    <= 1'b1;
      OE_N_O    <= 1'b1;
      WE_N_O    <= 1'b1;
      BYTE_N_O  <= 1'b1;
      RESET_N_O <= 1'b0;
      ADDR_O    <= 20'h00000;
      DQ_O      <= 16'h0000;
      DQ_OE_O   <= 16'h0000;
    end else begin
      DONE_O <= 1'b0;
      BUSY_O <= ~rb_s;
      case (state_ff)
        ST_RST_LOW: begin
          // Held for the minimum pulse width, all else released
          if (cnt_done) begin
            RESET_N_O <= 1'b1;
            cnt_ff    <= ABORTED_O ? CYC_RDY_B : CYC_RDY_I;
            state_ff  <= ST_RST_WAIT;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ST_RST_WAIT: begin
          // Busy case may finish early once ready_busy_n rises
          if (cnt_done || (ABORTED_O && rb_s)) begin
            cnt_ff   <= CYC_RH;
            state_ff <= ST_RECOV;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ST_RECOV: begin
          if (cnt_done) begin
            READY_O  <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ST_IDLE: begin
          // CE high here keeps the device in standby
          if (RST_REQ_I) begin
            READY_O   <= 1'b0;
            RESET_N_O <= 1'b0;
            // Same view of busy as BUSY_O, so software sees one story
            ABORTED_O <= BUSY_O;
            cnt_ff    <= CYC_RP;
            state_ff  <= ST_RST_LOW;
          end else if (REQ_I) begin
            READY_O  <= 1'b0;
            CE_N_O   <= 1'b0;
            BYTE_N_O <= ~BYTE_MODE_I;
            ADDR_O   <= pin_addr(BYTE_MODE_I, ADDR_I);
            if (WR_I) begin
              WE_N_O <= 1'b0;
              if (BYTE_MODE_I) begin
                DQ_O    <= {ADDR_I[0], 7'h00, WDATA_I[7:0]};
                DQ_OE_O <= `FHC_OE_BYTE_WR;
              end else begin
                DQ_O    <= WDATA_I;
                DQ_OE_O <= `FHC_OE_WORD;
              end
              cnt_ff   <= CYC_WE_LO;
              state_ff <= ST_WR;
            end else begin
              OE_N_O <= 1'b0;
              // Byte mode still drives the LSB address on pin 15
              DQ_O    <= {ADDR_I[0], 15'h0000};
              DQ_OE_O <= BYTE_MODE_I ? `FHC_OE_BYTE_RD : 16'h0000;
              cnt_ff   <= CYC_RD;
              state_ff <= ST_RD;
            end
          end
        end
        ST_RD: begin
          // Wait covers access time plus synchroniser latency
          if (cnt_done) begin
            RDATA_O  <= rd_lane(BYTE_N_O, dq_s);
            CE_N_O   <= 1'b1;
            OE_N_O   <= 1'b1;
            DQ_OE_O  <= 16'h0000;
            DONE_O   <= 1'b1;
            READY_O  <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ST_WR: begin
          if (cnt_done) begin
            WE_N_O   <= 1'b1;
            cnt_ff   <= CYC_WE_HI;
            state_ff <= ST_WR_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ST_WR_HOLD: begin
          // Data held past the rising write edge
          if (cnt_done) begin
            CE_N_O   <= 1'b1;
            DQ_OE_O  <= 16'h0000;
            DONE_O   <= 1'b1;
            READY_O  <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= ST_RST_LOW;
          cnt_ff   <= CYC_RP;
        end
      endcase
    end
  end
endmodule

// File: rtl/fhc_top_unused_placeholder_never.v
`timescale 1ns/1ps

// File: bench/fhc_chk.sv
// Port checker for the flash host controller
`timescale 1ns/1ps
module fhc_chk (
  input wire        CLK_I,
  input wire        NRST_I,
  input wire        REQ_I,
  input wire        WR_I,
  input wire        BYTE_MODE_I,
  input wire        RST_REQ_I,
  input wire        READY_O,
  input wire        DONE_O,
  input wire        BUSY_O,
  input wire        ABORTED_O,
  input wire        CE_N_O,
  input wire        OE_N_O,
  input wire        WE_N_O,
  input wire        BYTE_N_O,
  input wire        RESET_N_O,
  input wire [15:0] DQ_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire take = READY_O && REQ_I && !RST_REQ_I;
  AST_RD_PINS: assert property (!OE_N_O |-> !CE_N_O && WE_N_O)
    else $error("read strobes wrong");
  AST_WR_PINS: assert property (!WE_N_O |-> !CE_N_O && OE_N_O)
    else $error("write strobes wrong");
  AST_RD_SEQ: assert property (take && !WR_I |=> !OE_N_O[*4] ##1 DONE_O)
    else $error("read cycle timing wrong");
  AST_WR_SEQ: assert property (take && WR_I |=> !WE_N_O[*2] ##1 WE_N_O ##2 DONE_O)
    else $error("write cycle timing wrong");
  AST_WIDTH: assert property (take |=> BYTE_N_O == !$past(BYTE_MODE_I))
    else $error("width pin wrong");
  AST_BYTE_FLOAT: assert property (!BYTE_N_O |-> DQ_OE_O[14:8] == 7'h00)
    else $error("upper data driven in byte mode");
  AST_RST_HOLD: assert property ($fell(RESET_N_O) |-> !RESET_N_O[*6] ##1 RESET_N_O)
    else $error("reset pulse length wrong");
  AST_RST_QUIET: assert property (!RESET_N_O |-> CE_N_O)
    else $error("access during reset");
  AST_RECOV: assert property ($rose(RESET_N_O) |-> (!READY_O && CE_N_O)[*2])
    else $error("recovery wait missing");
  AST_ABORT: assert property (READY_O && RST_REQ_I |=> ABORTED_O == $past(BUSY_O))
    else $error("abort flag wrong");
endmodule
bind fhc_top fhc_chk u_chk (.*);

// File: bench/fhc_flash_model.sv
// Behavioural model of the flash device
`timescale 1ns/1ps
module fhc_flash_model #(
  parameter [15:0] PROG_CODE  = 16'h00a5,
  parameter [15:0] ERASE_CODE = 16'h0063,
  parameter [15:0] ID_CODE    = 16'h0061,
  parameter [15:0] EXIT_CODE  = 16'h0062,
  parameter [7:0]  ID_VALUE   = 8'h5c, // Arbitrary identification value
  parameter        BUSY_CYC   = 60,
  parameter        ERASE_CYC  = 90,
  parameter        RDY_CYC    = 30
) (
  input  wire        clk_i,
  input  wire        ce_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire        byte_n_i,
  input  wire        reset_n_i,
  input  wire [19:0] addr_i,
  input  wire [15:0] dq_i,
  output reg  [15:0] dq_o,
  output wire        ready_busy_n_o
);
  // Power-up lands in array read, idle
  integer cnt_ff  = 0;
  reg     tog_ff  = 1'b0;
  reg     id_ff   = 1'b0;
  reg     we_q_ff = 1'b1;
  wire        wr_end = we_n_i && !we_q_ff && !ce_n_i;
  // Byte configuration carries only the low data lane
  wire [15:0] wr_val = byte_n_i ? dq_i : {8'h00, dq_i[7:0]};
  assign ready_busy_n_o = (cnt_ff == 0);
  always @(posedge clk_i) begin
    tog_ff <= ~tog_ff;
    we_q_ff <= we_n_i;
    if (!reset_n_i) begin
      if (cnt_ff != 0) cnt_ff <= RDY_CYC;
      id_ff <= 1'b0;
    end else if (wr_end && wr_val == PROG_CODE) begin
      cnt_ff <= BUSY_CYC;
    end else if (wr_end && wr_val == ERASE_CODE) begin
      cnt_ff <= ERASE_CYC;
    end else if (wr_end && wr_val == ID_CODE) begin
      id_ff <= 1'b1;
    end else if (wr_end && wr_val == EXIT_CODE) begin
      id_ff <= 1'b0;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  // Undriven pins toggle so a stale value never looks valid
  always @* begin
    dq_o = {16{tog_ff}};
    if (reset_n_i && !ce_n_i && !oe_n_i && we_n_i) begin
      if (cnt_ff != 0) dq_o[7:0] = 8'h80;
      else if (id_ff) dq_o[7:0] = ID_VALUE;
      else if (byte_n_i) dq_o = addr_i[15:0] ^ 16'h5a3c;
      else dq_o[7:0] = {addr_i[6:0], dq_i[15]} ^ 8'h3c;
    end
  end
endmodule

// File: bench/tb_fhc_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_fhc_top;
  localparam [15:0] PROG  = 16'h00a5;
  localparam [15:0] ERASE = 16'h0063;
  localparam [15:0] IDC   = 16'h0061;
  localparam [15:0] IDX   = 16'h0062;
  localparam [7:0]  IDV   = 8'h5c; // Arbitrary identification value
  reg         CLK_I = 1'b0, NRST_I = 1'b0, REQ_I = 1'b0, WR_I = 1'b0;
  reg         BYTE_MODE_I = 1'b0, RST_REQ_I = 1'b0;
  reg  [20:0] ADDR_I = 21'h000000;
  reg  [15:0] WDATA_I = 16'h0000;
  wire [15:0] DQ_I, RDATA_O, DQ_O, DQ_OE_O;
  wire        READY_BUSY_N_I, READY_O, DONE_O, BUSY_O, ABORTED_O;
  wire        CE_N_O, OE_N_O, WE_N_O, BYTE_N_O, RESET_N_O;
  wire [19:0] ADDR_O;
  integer     checks = 0, failures = 0;
  always #50 CLK_I = ~CLK_I;
  fhc_top dut (.*);
  fhc_flash_model #(.PROG_CODE(PROG), .ERASE_CODE(ERASE), .ID_CODE(IDC),
    .EXIT_CODE(IDX), .ID_VALUE(IDV)) flash (.clk_i(CLK_I), .ce_n_i(CE_N_O),
    .oe_n_i(OE_N_O), .we_n_i(WE_N_O), .byte_n_i(BYTE_N_O),
    .reset_n_i(RESET_N_O), .addr_i(ADDR_O), .dq_i(DQ_O), .dq_o(DQ_I),
    .ready_busy_n_o(READY_BUSY_N_I));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for a level on a flag
  task wlev(input integer which, input v);
    integer n;
    begin
      n = 0;
      @(posedge CLK_I);
      while ((which == 0 ? READY_O : which == 1 ? DONE_O : BUSY_O) !== v
             && n < 400) begin
        @(posedge CLK_I);
        n = n + 1;
      end
      if (n >= 400) begin
        failures = failures + 1;
        $display("unexpected at %0t: wait limit reached", $time);
      end
    end
  endtask
  task acc(input w, input b, input [20:0] a, input [15:0] d);
    begin
      REQ_I <= 1'b1;
      WR_I <= w;
      BYTE_MODE_I <= b;
      ADDR_I <= a;
      WDATA_I <= d;
      wlev(0, 1'b1);
      REQ_I <= 1'b0;
      wlev(1, 1'b1);
      chk({15'h0000, DONE_O}, 16'h0001);
    end
  endtask
  task rst(input ab);
    begin
      RST_REQ_I <= 1'b1;
      wlev(0, 1'b1);
      RST_REQ_I <= 1'b0;
      @(posedge CLK_I);
      wlev(0, 1'b1);
      chk({15'h0000, ABORTED_O}, {15'h0000, ab});
    end
  endtask
  task t_read;
    begin
      acc(1'b0, 1'b0, 21'h00a5f0, 16'h0000);
      chk(RDATA_O, 16'ha5f0 ^ 16'h5a3c);
      acc(1'b0, 1'b0, 21'h0f0f0f, 16'h0000);
      chk(RDATA_O, 16'h0f0f ^ 16'h5a3c);
    end
  endtask
  task t_byte;
    begin
      acc(1'b0, 1'b1, 21'h1abcd, 16'h0000);
      chk(RDATA_O, {8'h00, 8'hcd ^ 8'h3c});
      acc(1'b0, 1'b1, 21'h1abcc, 16'h0000);
      chk(RDATA_O, {8'h00, 8'hcc ^ 8'h3c});
    end
  endtask
  // Identification entered and left by byte-wide command writes
  task t_ident;
    begin
      acc(1'b1, 1'b1, 21'h000aab, IDC);
      acc(1'b0, 1'b0, 21'h000001, 16'h0000);
      chk({8'h00, RDATA_O[7:0]}, {8'h00, IDV});
      acc(1'b0, 1'b1, 21'h000002, 16'h0000);
      chk(RDATA_O, {8'h00, IDV});
      acc(1'b1, 1'b1, 21'h000aaa, IDX);
      acc(1'b0, 1'b0, 21'h000001, 16'h0000);
      chk(RDATA_O, 16'h0001 ^ 16'h5a3c);
    end
  endtask
  task t_erase;
    begin
      acc(1'b1, 1'b0, 21'h0a5000, ERASE);
      wlev(2, 1'b1);
      chk({15'h0000, BUSY_O}, 16'h0001);
      acc(1'b0, 1'b0, 21'h0a5000, 16'h0000);
      chk({8'h00, RDATA_O[7:0]}, 16'h0080);
      wlev(2, 1'b0);
      chk({15'h0000, BUSY_O}, 16'h0000);
    end
  endtask
  // Bypass program: one unlock write then the data write
  task t_prog;
    begin
      acc(1'b1, 1'b0, 21'h000555, 16'h00aa);
      acc(1'b1, 1'b0, 21'h012340, PROG);
      wlev(2, 1'b1);
      chk({15'h0000, BUSY_O}, 16'h0001);
      acc(1'b0, 1'b0, 21'h012340, 16'h0000);
      chk({8'h00, RDATA_O[7:0]}, 16'h0080);
      wlev(2, 1'b0);
      chk({15'h0000, BUSY_O}, 16'h0000);
    end
  endtask
  task t_rst_busy;
    begin
      acc(1'b1, 1'b0, 21'h012342, PROG);
      wlev(2, 1'b1);
      rst(1'b1);
      chk({15'h0000, BUSY_O}, 16'h0000);
      acc(1'b0, 1'b0, 21'h012342, 16'h0000);
      chk(RDATA_O, 16'h2342 ^ 16'h5a3c);
    end
  endtask
  task t_rst_idle;
    begin
      rst(1'b0);
      acc(1'b0, 1'b1, 21'h000011, 16'h0000);
      chk(RDATA_O, {8'h00, 8'h11 ^ 8'h3c});
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge CLK_I);
    NRST_I <= 1'b1;
    t_read;
    t_byte;
    t_ident;
    t_prog;
    t_erase;
    t_rst_busy;
    t_rst_idle;
    results;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    #300000;
    failures = failures + 1;
    results;
  end
endmodule
